// ==== verilog/rotrng_pkg.sv ====
// shared constants and types for the ring oscillator fingerprint and random tile
package rotrng_pkg;
    localparam int          NUM_OSC        = 8;
    localparam int          NUM_PAIRS      = 4;
    localparam int          HALF_BASE      = 2;
    localparam int          CNT_W          = 8;
    localparam int          ADDR_W         = 5;
    localparam int          RANDOM_BYTE_MODE_ROUNDS    = 8;
    localparam logic [7:0]  WINDOW_RESET   = 8'h40;
    localparam logic [4:0]  ADDR_WINDOW    = 5'h00;
    localparam logic [4:0]  ADDR_RESULT    = 5'h00;
    localparam logic [1:0]  MODE_FINGER    = 2'h0;
    localparam logic [1:0]  MODE_RANDOM    = 2'h2;
    localparam logic [7:0]  UIO_OE_VALUE   = 8'hc0;
    localparam int          BIT_WRITE      = 0;
    localparam int          BIT_READ       = 1;
    localparam int          BIT_START      = 2;
    localparam int          BIT_MODE_LO    = 3;
    localparam int          BIT_ADDR_CLR   = 5;
    localparam int          BIT_BUSY       = 6;
    localparam int          BIT_DONE       = 7;
    // done shows on edge window plus this, counting the start edge as edge one
    localparam logic [8:0]  DONE_LATENCY   = 9'h002;

    typedef struct packed {
        logic       addr_clr;
        logic [1:0] mode;
        logic       start;
        logic       read_strobe;
        logic       write_strobe;
    } rotrng_ctrl_t;
endpackage

// ==== verilog/rotrng_top.sv ====
// ring oscillator tile: 4-bit fingerprint or random byte over an 8-bit strobe bus
// Summary of operation
// - eight oscillator models, half period index plus two
// - all run for window cycles, default 64
// - rising edges counted per oscillator, 8 bits
// - fingerprint bit i is cnt[2i] > cnt[2i+1]
// - random bit is XOR of counter LSBs
// - random mode runs eight rounds per byte
// - fingerprint done at window plus two cycles
// - byte address increments on every strobe without start or clear
// - write at address 0 loads a nonzero window length when not busy
// - read at address 0 drives result byte
// - start in mode 00 or 10 begins measurement when not busy, any start clears address
// - address clear zeroes address, no measurement
// - mode 00 fingerprint, mode 10 random
// - busy high while measuring
// - done high when result is readable
// - output enable vector held at c0
`timescale 1ns/1ps
module rotrng_top (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] data_input_byte,
    output logic      [7:0] data_output_byte,
    input  wire logic [7:0] uio_in,
    output logic      [7:0] uio_out,
    output logic      [7:0] uio_oe
);
    import rotrng_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_MEASURE, ST_SETTLE, ST_DONE} rotrng_state_t;

    rotrng_ctrl_t                ctrl;
    rotrng_state_t               state_q;
    logic [ADDR_W-1:0]           addr_q;
    logic [7:0]                  window_q;
    logic [7:0]                  win_cnt_q;
    logic [2:0]                  round_q;
    logic                        random_q;
    logic [7:0]                  result_q;
    logic [7:0]                  shift_q;
    logic [7:0]                  data_out_q;
    logic                        busy_q;
    logic                        done_q;
    logic [NUM_OSC-1:0]          osc_q;
    logic [NUM_OSC-1:0]          osc_prev_q;
    logic [CNT_W-1:0]            cnt_q [NUM_OSC];
    logic [3:0]                  div_q [NUM_OSC];
    logic                        counting;
    logic                        last_cycle;
    logic                        random_bit;
    logic [NUM_PAIRS-1:0]        puf_bits;
    logic                        take_start;

    assign ctrl       = rotrng_ctrl_t'(uio_in[BIT_ADDR_CLR:BIT_WRITE]);
    assign counting   = (state_q == ST_MEASURE);
    assign last_cycle = counting && (win_cnt_q == window_q - 8'h01);
    assign take_start = ctrl.start && (ctrl.mode == MODE_FINGER || ctrl.mode == MODE_RANDOM);

    // oscillator models run freely; only edges inside the window are counted
    genvar gi;
    generate
        for (gi = 0; gi < NUM_OSC; gi++) begin : g_osc
            localparam logic [3:0] HALF = 4'(gi + HALF_BASE);
            always_ff @(posedge core_clk) begin
                if (!rst_n) begin
                    div_q[gi] <= 4'h0;
                    osc_q[gi] <= 1'b0;
                end else if (div_q[gi] == HALF - 4'h1) begin
                    div_q[gi] <= 4'h0;
                    osc_q[gi] <= ~osc_q[gi];
                end else begin
                    div_q[gi] <= div_q[gi] + 4'h1;
                end
            end
            always_ff @(posedge core_clk) begin
                if (!rst_n) begin
                    osc_prev_q[gi] <= 1'b0;
                    cnt_q[gi]      <= 8'h00;
                end else begin
                    osc_prev_q[gi] <= osc_q[gi];
                    if (state_q == ST_IDLE || state_q == ST_DONE || state_q == ST_SETTLE) begin
                        if (take_start || state_q == ST_SETTLE) begin
                            cnt_q[gi] <= 8'h00;
                        end
                    end else if (osc_q[gi] && !osc_prev_q[gi]) begin
                        cnt_q[gi] <= cnt_q[gi] + 8'h01;
                    end
                end
            end
        end
        for (gi = 0; gi < NUM_PAIRS; gi++) begin : g_pair
            assign puf_bits[gi] = cnt_q[2*gi] > cnt_q[2*gi+1];
        end
    endgenerate

    always_comb begin
        random_bit = 1'b0;
        for (int k = 0; k < NUM_OSC; k++) begin
            random_bit = random_bit ^ cnt_q[k][0];
        end
    end

    // measurement sequencer
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_q   <= ST_IDLE;
            win_cnt_q <= 8'h00;
            round_q   <= 3'h0;
            random_q  <= 1'b0;
            result_q  <= 8'h00;
            shift_q   <= 8'h00;
            busy_q    <= 1'b0;
            done_q    <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE, ST_DONE: begin
                    if (take_start) begin
                        state_q   <= ST_MEASURE;
                        random_q  <= (ctrl.mode == MODE_RANDOM);
                        win_cnt_q <= 8'h00;
                        round_q   <= 3'h0;
                        busy_q    <= 1'b1;
                        done_q    <= 1'b0;
                    end
                end
                ST_MEASURE: begin
                    win_cnt_q <= win_cnt_q + 8'h01;
                    if (last_cycle) begin
                        state_q <= ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    // counters hold their final value here, one cycle after the window
                    win_cnt_q <= 8'h00;
                    if (!random_q) begin
                        result_q <= {4'h0, puf_bits};
                        state_q  <= ST_DONE;
                        busy_q   <= 1'b0;
                        done_q   <= 1'b1;
                    end else if (round_q == 3'(RANDOM_BYTE_MODE_ROUNDS - 1)) begin
                        result_q <= {shift_q[6:0], random_bit};
                        state_q  <= ST_DONE;
                        busy_q   <= 1'b0;
                        done_q   <= 1'b1;
                    end else begin
                        shift_q <= {shift_q[6:0], random_bit};
                        round_q <= round_q + 3'h1;
                        state_q <= ST_MEASURE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // strobe bus: address counter, window register, read data
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            addr_q     <= 5'h00;
            window_q   <= WINDOW_RESET;
            data_out_q <= 8'h00;
        end else begin
            if (ctrl.start || ctrl.addr_clr) begin
                addr_q <= 5'h00;
            end else if (ctrl.write_strobe || ctrl.read_strobe) begin
                addr_q <= addr_q + 5'h01;
            end
            // a zero window would wrap to 256 cycles, so it is ignored
            if (ctrl.write_strobe && addr_q == ADDR_WINDOW && data_input_byte != 8'h00 &&
                !busy_q) begin
                window_q <= data_input_byte;
            end
            if (ctrl.read_strobe && addr_q == ADDR_RESULT) begin
                data_out_q <= result_q;
            end
        end
    end

    assign data_output_byte = data_out_q;
    assign uio_out          = {done_q, busy_q, 6'h00};
    assign uio_oe           = UIO_OE_VALUE;

    // assertions
    logic [8:0] since_start_q;
    logic       fp_run_q;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            since_start_q <= 9'h000;
            fp_run_q      <= 1'b0;
        end else if (take_start && !busy_q) begin
            since_start_q <= 9'h000;
            fp_run_q      <= (ctrl.mode == MODE_FINGER);
        end else if (fp_run_q && !done_q) begin
            since_start_q <= since_start_q + 9'h001;
        end
    end

    sequence s_finish;
        busy_q ##1 (!busy_q && done_q);
    endsequence

    property p_done_time;
        @(posedge core_clk) disable iff (!rst_n)
        (fp_run_q && $rose(done_q)) |-> (since_start_q == {1'b0, window_q} + DONE_LATENCY - 9'h001);
    endproperty
    a_done_time: assert property (p_done_time) else $error("done late or early");

    property p_busy_done_excl;
        @(posedge core_clk) disable iff (!rst_n) !(busy_q && done_q);
    endproperty
    a_busy_done_excl: assert property (p_busy_done_excl) else $error("busy with done");

    property p_busy_to_done;
        @(posedge core_clk) disable iff (!rst_n) $fell(busy_q) |-> done_q;
    endproperty
    a_busy_to_done: assert property (p_busy_to_done) else $error("busy fell without done");

    property p_start_busy;
        @(posedge core_clk) disable iff (!rst_n) (take_start && !busy_q) |=> busy_q;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("start ignored");

    property p_result_stable;
        @(posedge core_clk) disable iff (!rst_n) (done_q && !take_start) |=> $stable(result_q);
    endproperty
    a_result_stable: assert property (p_result_stable) else $error("result moved");

    property p_addr_inc;
        @(posedge core_clk) disable iff (!rst_n)
        (ctrl.write_strobe && !ctrl.start && !ctrl.addr_clr) |=> addr_q == $past(addr_q) + 5'h01;
    endproperty
    a_addr_inc: assert property (p_addr_inc) else $error("address did not advance");

    property p_addr_clr;
        @(posedge core_clk) disable iff (!rst_n) (ctrl.addr_clr || ctrl.start) |=> addr_q == 5'h00;
    endproperty
    a_addr_clr: assert property (p_addr_clr) else $error("address not cleared");

    property p_clr_no_start;
        @(posedge core_clk) disable iff (!rst_n)
        (ctrl.addr_clr && !ctrl.start && !busy_q) |=> !busy_q;
    endproperty
    a_clr_no_start: assert property (p_clr_no_start) else $error("clear started work");

    property p_read_data;
        @(posedge core_clk) disable iff (!rst_n)
        (ctrl.read_strobe && addr_q == ADDR_RESULT) |=> data_output_byte == $past(result_q);
    endproperty
    a_read_data: assert property (p_read_data) else $error("read data wrong");

    property p_fp_upper;
        @(posedge core_clk) disable iff (!rst_n)
        (done_q && !random_q) |-> result_q[7:4] == 4'h0;
    endproperty
    a_fp_upper: assert property (p_fp_upper) else $error("fingerprint upper bits set");

    property p_finish_seq;
        @(posedge core_clk) disable iff (!rst_n) $rose(done_q) |-> $past(busy_q);
    endproperty
    a_finish_seq: assert property (p_finish_seq) else $error("done without measurement");

    // the last settle cycle must hand over from busy to done in one step
    property p_settle_finish;
        @(posedge core_clk) disable iff (!rst_n)
        (state_q == ST_SETTLE && (!random_q || round_q == 3'(RANDOM_BYTE_MODE_ROUNDS - 1))) |-> s_finish;
    endproperty
    a_settle_finish: assert property (p_settle_finish) else $error("no busy to done handover");

    property p_oe;
        @(posedge core_clk) disable iff (!rst_n) uio_oe == 8'hc0;
    endproperty
    a_oe: assert property (p_oe) else $error("output enable wrong");
endmodule // rotrng_top

// ==== testbench/rotrng_host.sv ====
// host model driving the strobe bus of the oscillator tile
`timescale 1ns/1ps
module rotrng_host (
    input  wire logic       core_clk,
    output logic            rst_n,
    output logic      [7:0] data_input_byte,
    output logic      [7:0] uio_in
);
    import rotrng_pkg::*;
    int seed = 32'h108c68af;
    initial begin
        rst_n           = 1'b0;
        data_input_byte = 8'h00;
        uio_in          = 8'h00;
    end
    function automatic logic [7:0] rnd();
        return 8'($random(seed));
    endfunction
    // held far past the minimum so every register sees several reset edges
    task automatic do_reset();
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
    endtask
    // high across exactly one edge; idle puts noise on the ignored bits only
    task automatic pulse(input logic [7:0] v, input logic [7:0] d);
        @(posedge core_clk);
        uio_in          <= v;
        data_input_byte <= d;
        @(posedge core_clk);
        uio_in          <= {rnd() & 8'hc0};
        data_input_byte <= rnd();
    endtask
endmodule // rotrng_host

// ==== testbench/tb_top.sv ====
// self-checking bench for the oscillator tile
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
    import rotrng_pkg::*;
    logic        core_clk = 1'b0;
    wire         rst_n;
    wire  [7:0]  data_input_byte;
    wire  [7:0]  uio_in;
    logic [7:0]  data_output_byte;
    logic [7:0]  uio_out;
    logic [7:0]  uio_oe;
    int          n_mismatch = 0;
    int          n_checks = 0;
    logic [15:0] exp_q [$];
    logic [15:0] note;
    logic [7:0]  win;
    int          n;

    always #50 core_clk = ~core_clk;

    rotrng_host host (.core_clk(core_clk), .rst_n(rst_n),
                      .data_input_byte(data_input_byte), .uio_in(uio_in));
    rotrng_top dut (.core_clk(core_clk), .rst_n(rst_n), .data_input_byte(data_input_byte),
                    .data_output_byte(data_output_byte), .uio_in(uio_in),
                    .uio_out(uio_out), .uio_oe(uio_oe));

    // each read strobe yields one note: {mask, value}
    always @(posedge core_clk) begin
        if (rst_n === 1'b1 && uio_in[BIT_READ] === 1'b1) begin
            #1;
            note = exp_q.pop_front();
            `CHK(data_output_byte & note[15:8], note[7:0])
        end
    end

    task automatic read_res(input logic clr, input logic [7:0] m, input logic [7:0] e);
        if (clr) host.pulse(8'h20, 8'h00);
        exp_q.push_back({m, e});
        host.pulse(8'h02, 8'h00);
    endtask

    // cyc counts edges from the start edge to the first edge showing done
    task automatic run(input logic [7:0] v, output int cyc);
        host.pulse(v, 8'h00);
        cyc = 1;
        #1;
        while (uio_out[BIT_DONE] !== 1'b1 && cyc < 3000) begin
            `CHK(uio_out[BIT_BUSY], 1'b1)
            @(posedge core_clk);
            #1;
            cyc++;
        end
        `CHK(uio_out[BIT_BUSY], 1'b0)
    endtask

    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        host.do_reset();
        @(posedge core_clk);
        #1;
        `CHK({uio_oe, uio_out, data_output_byte}, {UIO_OE_VALUE, 16'h0000})
        run(8'h04, n);
        `CHK(n, int'(WINDOW_RESET) + 2)
        read_res(1'b1, 8'hf0, 8'h00);
        // zero window refused but the address still moves on
        host.pulse(8'h20, 8'h00);
        host.pulse(8'h01, 8'h00);
        host.pulse(8'h20, 8'h00);
        // 161 cycles keeps every pair apart whatever the oscillator phase
        host.pulse(8'h01, 8'ha1);
        host.pulse(8'h01, 8'h05);
        run(8'h04, n);
        `CHK(n, 32'ha1 + 2)
        read_res(1'b0, 8'hff, 8'h0f);
        read_res(1'b0, 8'hff, 8'h0f);
        host.pulse(8'h0c, 8'h00);
        #1;
        `CHK(uio_out[7:6], 2'b10)
        win = 8'h04 + (host.rnd() & 8'h0f);
        host.pulse(8'h20, 8'h00);
        host.pulse(8'h01, win);
        run(8'h14, n);
        `CHK(n >= 8 * win && n <= 8 * (win + 2) + 2, 1'b1)
        read_res(1'b1, 8'h00, 8'h00);
        `CHK(uio_out[7:6], 2'b10)
        wrap_up();
    end

    initial begin
        #(100 * 5000);
        n_mismatch++;
        wrap_up();
    end
endmodule // tb_top
